// *** core/acpc_core.v ***
// Auxiliary clock PLL control: APB registers, decode and lock tracking
`include "acpc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module acpc_core (
    input  wire        clk_sys,
    input  wire        nrst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Analog PLL and oscillator side
    input  wire        pllPhaseLock,
    output wire        auxPllEnable,
    output wire        usbClkFromPll,
    output wire        extClkModeEn,
    output wire        xtalModeEn,
    output wire        hsXtalModeEn,
    output wire        auxOscOff,
    output wire        refPrimarySel,
    output wire        refRcSel,
    output wire        divSrcAlternate,
    output reg  [3:0]  postDivLog2,
    output reg  [4:0]  preDivRatio,
    output reg  [5:0]  fbMultRatio,
    output wire [2:0]  fbMultCode,
    // Interrupt
    output wire        irq
);

    // -----------------------------------------------------------------------
    // Register storage
    // -----------------------------------------------------------------------
    reg        enableReg;
    reg        lockedReg;
    reg        divSrcReg;
    reg  [1:0] modeReg;
    reg        primSelReg;
    reg        rcSelReg;
    reg  [2:0] postReg;
    reg  [2:0] preReg;
    reg  [2:0] multReg;
    reg  [1:0] irqStatReg;
    reg  [1:0] irqMaskReg;

    reg  [1:0] irqStatNext;
    reg  [31:0] readData;
    reg        addrHit;

    wire       lockSync;
    wire       setupPhase;
    wire       wrAccess;
    wire       lockNext;
    wire       lockGain;
    wire       lockLoss;
    wire [15:0] ctrlView;

    // -----------------------------------------------------------------------
    // Lock input synchroniser
    // -----------------------------------------------------------------------
    acpc_sync3 #(
        .RESET_LEVEL (1'b0)
    ) uLockSync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .asyncIn (pllPhaseLock),
        .syncOut (lockSync)
    );

    // -----------------------------------------------------------------------
    // APB handshake
    // -----------------------------------------------------------------------
    assign setupPhase = psel & ~penable;
    assign wrAccess   = psel & penable & pwrite;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~addrHit;

    always @* begin
        case (paddr)
            `ACPC_OFS_CTRL:    addrHit = 1'b1;
            `ACPC_OFS_MULT:    addrHit = 1'b1;
            `ACPC_OFS_IRQSTAT: addrHit = 1'b1;
            `ACPC_OFS_IRQMASK: addrHit = 1'b1;
            default:           addrHit = 1'b0;
        endcase
    end

    // -----------------------------------------------------------------------
    // Control register writes
    // -----------------------------------------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            enableReg  <= 1'b0;
            divSrcReg  <= 1'b0;
            modeReg    <= 2'h0;
            primSelReg <= 1'b0;
            rcSelReg   <= 1'b0;
            postReg    <= 3'h0;
            preReg     <= 3'h0;
            multReg    <= `ACPC_MULT_RESET;
            irqMaskReg <= `ACPC_IRQ_RESET;
        end else if (wrAccess) begin
            if (paddr == `ACPC_OFS_CTRL) begin
                if (pstrb[1]) begin
                    enableReg  <= pwdata[`ACPC_CTRL_ENABLE];
                    divSrcReg  <= pwdata[`ACPC_CTRL_DIVSRC];
                    modeReg    <= pwdata[`ACPC_CTRL_MODE_HI:`ACPC_CTRL_MODE_LO];
                    primSelReg <= pwdata[`ACPC_CTRL_PRIMSEL];
                    rcSelReg   <= pwdata[`ACPC_CTRL_RCSEL];
                end
                if (pstrb[0]) begin
                    postReg <= pwdata[`ACPC_CTRL_POST_HI:`ACPC_CTRL_POST_LO];
                    preReg  <= pwdata[`ACPC_CTRL_PRE_HI:`ACPC_CTRL_PRE_LO];
                end
            end
            if (paddr == `ACPC_OFS_MULT && pstrb[0]) begin
                // Upper bits have no storage
                multReg <= pwdata[`ACPC_MULT_HI:`ACPC_MULT_LO];
            end
            if (paddr == `ACPC_OFS_IRQMASK && pstrb[0]) begin
                irqMaskReg <= pwdata[1:0];
            end
        end
    end

    // -----------------------------------------------------------------------
    // Lock status
    // -----------------------------------------------------------------------
    // Status only follows a settled lock while the PLL is running
    assign lockNext = enableReg & lockSync;
    assign lockGain = lockNext & ~lockedReg;
    assign lockLoss = ~lockNext & lockedReg;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lockedReg <= 1'b0;
        end else begin
            lockedReg <= lockNext;
        end
    end

    // -----------------------------------------------------------------------
    // Interrupt status, write one to clear, new events win
    // -----------------------------------------------------------------------
    always @* begin
        irqStatNext = irqStatReg;
        if (wrAccess && paddr == `ACPC_OFS_IRQSTAT && pstrb[0]) begin
            irqStatNext = irqStatNext & ~pwdata[1:0];
        end
        if (lockGain) begin
            irqStatNext[`ACPC_IRQ_LOCK_GAIN] = 1'b1;
        end
        if (lockLoss) begin
            irqStatNext[`ACPC_IRQ_LOCK_LOSS] = 1'b1;
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irqStatReg <= `ACPC_IRQ_RESET;
        end else begin
            irqStatReg <= irqStatNext;
        end
    end

    assign irq = |(irqStatReg & irqMaskReg);

    // -----------------------------------------------------------------------
    // Read path, captured in the setup phase
    // -----------------------------------------------------------------------
    assign ctrlView = {enableReg, lockedReg, divSrcReg, modeReg, primSelReg,
                       rcSelReg, 1'b0, postReg, 2'b00, preReg};

    always @* begin
        readData = 32'h0000_0000;
        case (paddr)
            `ACPC_OFS_CTRL:    readData = {16'h0000, ctrlView};
            `ACPC_OFS_MULT:    readData = {29'h0, multReg};
            `ACPC_OFS_IRQSTAT: readData = {30'h0, irqStatReg};
            `ACPC_OFS_IRQMASK: readData = {30'h0, irqMaskReg};
            default:           readData = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase && !pwrite) begin
            prdata <= readData;
        end
    end

    // -----------------------------------------------------------------------
    // Oscillator mode decode
    // -----------------------------------------------------------------------
    assign extClkModeEn = (modeReg == `ACPC_MODE_EXTCLK);
    assign xtalModeEn   = (modeReg == `ACPC_MODE_XTAL);
    assign hsXtalModeEn = (modeReg == `ACPC_MODE_HSXTAL);
    assign auxOscOff    = (modeReg == `ACPC_MODE_OFF);

    // -----------------------------------------------------------------------
    // Clock routing controls
    // -----------------------------------------------------------------------
    assign auxPllEnable    = enableReg;
    assign usbClkFromPll   = enableReg;
    assign divSrcAlternate = divSrcReg;
    assign refPrimarySel   = primSelReg;
    assign refRcSel        = rcSelReg;
    assign fbMultCode      = multReg;

    // -----------------------------------------------------------------------
    // Divider ratio decode, registered
    // -----------------------------------------------------------------------
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            postDivLog2 <= `ACPC_POST_CODE0_LOG;
        end else if (postReg == 3'h0) begin
            postDivLog2 <= `ACPC_POST_CODE0_LOG;
        end else begin
            postDivLog2 <= `ACPC_POST_TOP_CODE - {1'b0, postReg};
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            preDivRatio <= `ACPC_PRE_R0;
        end else begin
            case (preReg)
                3'h7:    preDivRatio <= `ACPC_PRE_R7;
                3'h6:    preDivRatio <= `ACPC_PRE_R6;
                3'h5:    preDivRatio <= `ACPC_PRE_R5;
                3'h4:    preDivRatio <= `ACPC_PRE_R4;
                3'h3:    preDivRatio <= `ACPC_PRE_R3;
                3'h2:    preDivRatio <= `ACPC_PRE_R2;
                3'h1:    preDivRatio <= `ACPC_PRE_R1;
                default: preDivRatio <= `ACPC_PRE_R0;
            endcase
        end
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            fbMultRatio <= `ACPC_MULT_BASE;
        end else if (multReg == `ACPC_MULT_TOP_CODE) begin
            fbMultRatio <= `ACPC_MULT_TOP_RAT;
        end else begin
            fbMultRatio <= `ACPC_MULT_BASE + {3'b000, multReg};
        end
    end

endmodule

`default_nettype wire

// *** core/acpc_defines.vh ***
// Offsets, field positions, reset values and decode tables of the aux clock control
// ---------------------------------------------------------------------------
// Summary of operation
// - Mode field 11 external clock, 10 crystal, 01 fast crystal, 00 off.
// - Three-bit postscaler divides VCO output by a power of two, low codes larger.
// - Three-bit prescaler divides reference before phase detector, ratios 10,6,5,4,3 included.
// - Feedback multiplier field sits in bits 2..0 of second register.
// - Bits 15..3 of second register read zero and ignore writes.
// - One select bit picks PLL/oscillator path or alternative clock for divider.
// ---------------------------------------------------------------------------
`ifndef ACPC_DEFINES_VH
`define ACPC_DEFINES_VH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define ACPC_OFS_CTRL      8'h00
`define ACPC_OFS_MULT      8'h04
`define ACPC_OFS_IRQSTAT   8'h08
`define ACPC_OFS_IRQMASK   8'h0c

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define ACPC_CTRL_ENABLE   15
`define ACPC_CTRL_LOCKED   14
`define ACPC_CTRL_DIVSRC   13
`define ACPC_CTRL_MODE_HI  12
`define ACPC_CTRL_MODE_LO  11
`define ACPC_CTRL_PRIMSEL  10
`define ACPC_CTRL_RCSEL    9
`define ACPC_CTRL_POST_HI  7
`define ACPC_CTRL_POST_LO  5
`define ACPC_CTRL_PRE_HI   2
`define ACPC_CTRL_PRE_LO   0
`define ACPC_MULT_HI       2
`define ACPC_MULT_LO       0

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define ACPC_CTRL_RESET    16'h0000
`define ACPC_MULT_RESET    3'h0
`define ACPC_IRQ_RESET     2'h0

// ---------------------------------------------------------------------------
// Interrupt status bits
// ---------------------------------------------------------------------------
`define ACPC_IRQ_LOCK_GAIN 0
`define ACPC_IRQ_LOCK_LOSS 1

// ---------------------------------------------------------------------------
// Oscillator mode codes
// ---------------------------------------------------------------------------
`define ACPC_MODE_OFF      2'h0
`define ACPC_MODE_HSXTAL   2'h1
`define ACPC_MODE_XTAL     2'h2
`define ACPC_MODE_EXTCLK   2'h3

// ---------------------------------------------------------------------------
// Postscaler: divide is two to the power given; code 0 gives the deepest
// ---------------------------------------------------------------------------
`define ACPC_POST_CODE0_LOG 4'h8
`define ACPC_POST_TOP_CODE  4'h7

// ---------------------------------------------------------------------------
// Prescaler ratios per code
// ---------------------------------------------------------------------------
`define ACPC_PRE_R7        5'h0c
`define ACPC_PRE_R6        5'h0a
`define ACPC_PRE_R5        5'h06
`define ACPC_PRE_R4        5'h05
`define ACPC_PRE_R3        5'h04
`define ACPC_PRE_R2        5'h03
`define ACPC_PRE_R1        5'h02
`define ACPC_PRE_R0        5'h01

// ---------------------------------------------------------------------------
// Feedback multiplier: ratio is base plus code, except the top code, which has its own ratio
// ---------------------------------------------------------------------------
`define ACPC_MULT_BASE     6'h0f
`define ACPC_MULT_TOP_CODE 3'h7
`define ACPC_MULT_TOP_RAT  6'h18

`endif

// *** core/acpc_sync3.v ***
// Three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/1ps
`default_nettype none

module acpc_sync3 #(
    parameter RESET_LEVEL = 1'b0
) (
    input  wire clk_sys,
    input  wire nrst,
    input  wire asyncIn,
    output reg  syncOut
);

    // -----------------------------------------------------------------------
    // Capture chain
    // -----------------------------------------------------------------------
    reg stage1Reg;
    reg stage2Reg;
    reg stage3Reg;

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            stage1Reg <= RESET_LEVEL;
            stage2Reg <= RESET_LEVEL;
            stage3Reg <= RESET_LEVEL;
            syncOut   <= RESET_LEVEL;
        end else begin
            stage1Reg <= asyncIn;
            stage2Reg <= stage1Reg;
            stage3Reg <= stage2Reg;
            // Change accepted only once stages two and three agree
            if (stage2Reg == stage3Reg) begin
                syncOut <= stage3Reg;
            end
        end
    end

endmodule

`default_nettype wire

// *** bench/acpc_pll_model.sv ***
// Behavioural analog PLL lock source for the aux clock control
`timescale 1ns/1ps
`default_nettype none

module acpc_pll_model (
    input  wire logic       clk_sys,
    input  wire logic       enable,
    input  wire logic       loseLock,
    input  wire logic [7:0] lockDelay,
    output logic            pllPhaseLock
);
    int cnt = 0;

    // Lock moves on the falling edge, away from the sampling edge
    always @(negedge clk_sys) begin
        if (!enable || loseLock) begin
            cnt <= 0;
            pllPhaseLock <= 1'b0;
        end else if (cnt >= lockDelay) begin
            pllPhaseLock <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

`default_nettype wire

// *** bench/acpc_core_chk.sv ***
// Port-level assertions for the aux clock control
`timescale 1ns/1ps
`default_nettype none

module acpc_core_chk (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        auxPllEnable,
    input wire logic        usbClkFromPll,
    input wire logic        extClkModeEn,
    input wire logic        xtalModeEn,
    input wire logic        hsXtalModeEn,
    input wire logic        auxOscOff,
    input wire logic        divSrcAlternate,
    input wire logic [3:0]  postDivLog2,
    input wire logic [4:0]  preDivRatio,
    input wire logic [5:0]  fbMultRatio,
    input wire logic [2:0]  fbMultCode
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    localparam logic [4:0] PRE_TAB [8] = '{5'h01, 5'h02, 5'h03, 5'h04,
                                           5'h05, 5'h06, 5'h0a, 5'h0c};
    wire logic acc = psel && penable;
    wire logic wrCtl = acc && pwrite && paddr == 8'h00;
    wire logic wrMul = acc && pwrite && paddr == 8'h04;

    mode_decode_a: assert property (wrCtl && pstrb[1] |=>
        {extClkModeEn, xtalModeEn, hsXtalModeEn, auxOscOff} == 4'h1 << $past(pwdata[12:11]))
        else $error("mode decode wrong");
    post_map_a: assert property (wrCtl && pstrb[0] |=> ##1 postDivLog2 ==
        ($past(pwdata[7:5], 2) == 3'h0 ? 4'h8 : 4'h7 - $past(pwdata[7:5], 2)))
        else $error("postscaler wrong");
    pre_map_a: assert property (wrCtl && pstrb[0] |=> ##1
        preDivRatio == PRE_TAB[$past(pwdata[2:0], 2)]) else $error("prescaler wrong");
    mult_map_a: assert property (wrMul && pstrb[0] |=> fbMultCode == $past(pwdata[2:0])
        ##1 fbMultRatio == ($past(pwdata[2:0], 2) == 3'h7 ? 6'h18 : 6'h0f + $past(pwdata[2:0], 2)))
        else $error("multiplier wrong");
    mult_zero_a: assert property (acc && !pwrite && paddr == 8'h04 |->
        prdata[31:3] == 29'h0) else $error("reserved bits not zero");
    select_bit_a: assert property (wrCtl && pstrb[1] |=>
        divSrcAlternate == $past(pwdata[13])) else $error("divider source wrong");
    enable_route_a: assert property (wrCtl && pstrb[1] |=>
        auxPllEnable == $past(pwdata[15]) && usbClkFromPll == auxPllEnable)
        else $error("enable routing wrong");
    err_resp_a: assert property (pslverr ==
        (acc && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})))
        else $error("error response wrong");
    prdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");

    cover property (wrCtl && pstrb == 4'h1);
    cover property (acc && pslverr);
    cover property (wrMul ##3 fbMultRatio == 6'h18);
endmodule

bind acpc_core acpc_core_chk acpc_core_chk_inst (.clk_sys, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pslverr, .auxPllEnable, .usbClkFromPll, .extClkModeEn,
    .xtalModeEn, .hsXtalModeEn, .auxOscOff, .divSrcAlternate, .postDivLog2, .preDivRatio,
    .fbMultRatio, .fbMultCode);

`default_nettype wire

// *** bench/auxiliary_clock_pll_control_test.sv ***
// Self-checking bench for the aux clock PLL control
`timescale 1ns/1ps
`default_nettype none

module auxiliary_clock_pll_control_test;
    logic        clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, lockDelay = 8'h04;
    logic [31:0] pwdata = 32'h0, prdata, rdVal;
    logic [3:0]  pstrb = 4'h0, postDivLog2;
    logic        pready, pslverr, pllPhaseLock, auxPllEnable, usbClkFromPll, irq;
    logic        extClkModeEn, xtalModeEn, hsXtalModeEn, auxOscOff, loseLock = 1'b0;
    logic        refPrimarySel, refRcSel, divSrcAlternate;
    logic [4:0]  preDivRatio;
    logic [5:0]  fbMultRatio;
    logic [2:0]  fbMultCode;
    int          miscompares = 0, total_checks = 0, cycles = 0;
    int          ctrlM = 0, multM = 0, statM = 0, maskM = 0, lk = 0;
    int          preTab [8] = '{1, 2, 3, 4, 5, 6, 10, 12};
    wire logic [3:0] modeVec = {extClkModeEn, xtalModeEn, hsXtalModeEn, auxOscOff};
    wire logic [4:0] selVec  = {divSrcAlternate, 2'b00, refPrimarySel, refRcSel};

    acpc_core acpc_core_inst (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .pllPhaseLock, .auxPllEnable, .usbClkFromPll,
        .extClkModeEn, .xtalModeEn, .hsXtalModeEn, .auxOscOff, .refPrimarySel, .refRcSel,
        .divSrcAlternate, .postDivLog2, .preDivRatio, .fbMultRatio, .fbMultCode, .irq);
    acpc_pll_model acpc_pll_model_inst (.clk_sys, .enable(auxPllEnable), .loseLock,
        .lockDelay, .pllPhaseLock);

    initial forever #25 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic outs();
        int p;
        p = ctrlM >> 5 & 7;
        chk("mode", 32'h1 << (ctrlM >> 11 & 3), modeVec);
        chk("post", p == 0 ? 8 : 7 - p, postDivLog2);
        chk("pre", preTab[ctrlM & 7], preDivRatio);
        chk("mult", multM == 7 ? 24 : 15 + multM, fbMultRatio);
        chk("code", multM, fbMultCode);
        chk("select", ctrlM >> 9 & 32'h13, selVec);
        chk("enable", (ctrlM >> 15 & 1) * 3, {usbClkFromPll, auxPllEnable});
        chk("irq", (statM & maskM) != 0, irq);
    endtask

    // APB transfer, shadow-register update and comparison of the answer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        logic [31:0] lm;
        lm = {16'h0, {8{s[1]}}, {8{s[0]}}};
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdVal = prdata;
        chk("pslverr", !(a inside {8'h00, 8'h04, 8'h08, 8'h0c}), pslverr);
        if (w) begin
            case (a)
                8'h00: ctrlM = ctrlM & ~lm | d & lm & 32'hbee7;
                8'h04: multM = multM & ~lm | d & lm & 32'h7;
                8'h08: statM = statM & ~(d & lm);
                8'h0c: maskM = maskM & ~lm | d & lm & 32'h3;
                default: ;
            endcase
        end else begin
            chk("read", a == 8'h00 ? ctrlM | lk << 14 : a == 8'h04 ? multM : a == 8'h08 ? statM
                : a == 8'h0c ? maskM : 0, rdVal);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clk_sys);
        outs();
    endtask

    initial begin
        void'($urandom(32'h09bd));
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        for (int a = 0; a < 20; a += 4) apb(0, a, 0, 0);
        $display("test done: reset values");
        for (int i = 0; i < 8; i++) begin
            apb(1, 8'h00, $urandom & 32'hffff6718 | i << 11 & 32'h1800 | i << 5 | 7 - i,
                i == 5 ? 4'h1 : 4'($urandom | 3));
            apb(0, 8'h00, 0, 0);
        end
        $display("test done: control fields");
        for (int i = 0; i < 8; i++) begin
            apb(1, 8'h04, $urandom & ~32'h7 | i, 4'hf);
            apb(0, 8'h04, 0, 0);
        end
        apb(1, 8'h10, $urandom, 4'hf);
        apb(1, 8'h06, $urandom, 4'hf);
        apb(0, 8'h06, 0, 0);
        $display("test done: multiplier and unmapped");
        apb(1, 8'h0c, 3, 4'hf);
        for (int k = 0; k < 2; k++) begin
            lockDelay <= k ? 8'd30 : 8'd4;
            apb(1, 8'h00, 32'h8000, 4'hf);
            apb(0, 8'h00, 0, 0);
            repeat (60) @(posedge clk_sys);
            lk = 1;
            statM = 1;
            apb(0, 8'h00, 0, 0);
            apb(1, 8'h08, 1, 4'hf);
            loseLock <= 1'b1;
            repeat (20) @(posedge clk_sys);
            lk = 0;
            statM = 2;
            apb(0, 8'h08, 0, 0);
            apb(1, 8'h0c, 1, 4'hf);
            apb(1, 8'h0c, 3, 4'hf);
            apb(1, 8'h08, 2, 4'hf);
            apb(1, 8'h00, 0, 4'hf);
            loseLock <= 1'b0;
            apb(0, 8'h08, 0, 0);
        end
        $display("test done: lock and interrupt");
        apb(1, 8'h00, 32'hffff, 4'hf);
        apb(1, 8'h0c, 3, 4'hf);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        ctrlM = 0;
        multM = 0;
        statM = 0;
        maskM = 0;
        lk = 0;
        @(posedge clk_sys);
        for (int a = 0; a < 16; a += 4) apb(0, a, 0, 0);
        $display("test done: mid-run reset");
        stop_test();
    end
endmodule

`default_nettype wire
